// file: art_pwm_timer.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module art_pwm_timer (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       NRST,
  // Register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // External prescaler input, one-cycle tick
  input  wire logic       EXT_TICK,
  // Pins
  output logic      [3:0] PWM_OUT,
  output logic      [3:0] PWM_OUT_EN_N,
  input  wire logic [1:0] CAP_IN,
  // Interrupt requests
  output logic            OVF_IRQ,
  output logic      [1:0] CAP_IRQ
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] duty_r [art_pkg::NUM_PWM];
  logic [7:0] compare_r [art_pkg::NUM_PWM];
  logic [7:0] pwm_output_control_r;
  logic [7:0] timer_control_status_r;
  logic [7:0] counter_r;
  logic [7:0] reload_value_r;
  logic [3:0] cap_ctrl_r;
  logic [1:0] cap_flag;
  logic [7:0] cap_value [art_pkg::NUM_CAP];
  logic [1:0] cap_read;
  logic [3:0] level_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  logic       wr_csr;
  logic       rd_csr;
  logic       force_reload;
  logic       run;
  logic       tick_src;
  logic       cnt_tick;
  logic       overflow;
  logic [3:0] polarity;

  assign wr_csr = WR && (ADDR == art_pkg::ADDR_TIMER_CSR);
  assign rd_csr = RD && (ADDR == art_pkg::ADDR_TIMER_CSR);
  assign force_reload = wr_csr && WDATA[art_pkg::CSR_FORCE];
  assign run = timer_control_status_r[art_pkg::CSR_RUN];
  assign tick_src = timer_control_status_r[art_pkg::CSR_EXT_CLK] ?
                    EXT_TICK : 1'b1;
  assign polarity = pwm_output_control_r[art_pkg::PWM_POL_LSB +: 4];

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  art_prescaler #(
    .WIDTH (art_pkg::PRESC_W)
  ) u_presc (
    .CLK      (CLK),
    .NRST     (NRST),
    .run      (run),
    .clear    (force_reload),
    .tick_in  (tick_src),
    .ratio    (timer_control_status_r[art_pkg::CSR_PRESC_LSB +: 3]),
    .tick_out (cnt_tick)
  );

  assign overflow = cnt_tick && (counter_r == art_pkg::COUNT_TOP);

  // ****************************************************************
  // Write side of plain registers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      for (int i = 0; i < art_pkg::NUM_PWM; i++) begin
        duty_r[i] <= art_pkg::REG_RESET;
      end
      pwm_output_control_r <= art_pkg::REG_RESET;
      reload_value_r       <= art_pkg::REG_RESET;
      cap_ctrl_r           <= 4'h0;
    end else if (WR) begin
      unique case (ADDR)
        art_pkg::ADDR_DUTY_CH3:    duty_r[3] <= WDATA;
        art_pkg::ADDR_DUTY_CH2:    duty_r[2] <= WDATA;
        art_pkg::ADDR_DUTY_CH1:    duty_r[1] <= WDATA;
        art_pkg::ADDR_DUTY_CH0:    duty_r[0] <= WDATA;
        art_pkg::ADDR_PWM_CTRL:    pwm_output_control_r <= WDATA;
        art_pkg::ADDR_RELOAD:      reload_value_r <= WDATA;
        // Only edge and enable bits are stored; flags are hardware's.
        art_pkg::ADDR_CAPTURE_CSR: cap_ctrl_r <= WDATA[5:2];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Timer control and status
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      timer_control_status_r <= art_pkg::REG_RESET;
    end else begin
      if (wr_csr) begin
        // Force bit is write-only, overflow flag is hardware-owned.
        timer_control_status_r[7:3] <= WDATA[7:3];
        timer_control_status_r[art_pkg::CSR_OVF_IE] <=
          WDATA[art_pkg::CSR_OVF_IE];
      end
      if (overflow) begin
        timer_control_status_r[art_pkg::CSR_OVF] <= 1'b1;
      end else if (rd_csr) begin
        timer_control_status_r[art_pkg::CSR_OVF] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      counter_r <= art_pkg::REG_RESET;
    end else if (force_reload) begin
      counter_r <= reload_value_r;
    end else if (WR && (ADDR == art_pkg::ADDR_COUNTER)) begin
      counter_r <= WDATA;
    end else if (overflow) begin
      counter_r <= reload_value_r;
    end else if (cnt_tick) begin
      counter_r <= counter_r + 8'h01;
    end
  end

  // ****************************************************************
  // PWM channels
  // ****************************************************************
  // Duty values move into the compare stage only at overflow, so a
  // period never sees a half-updated edge.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      for (int i = 0; i < art_pkg::NUM_PWM; i++) begin
        compare_r[i] <= art_pkg::REG_RESET;
      end
    end else if (overflow) begin
      for (int i = 0; i < art_pkg::NUM_PWM; i++) begin
        compare_r[i] <= duty_r[i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      level_r <= 4'h0;
    end else begin
      for (int i = 0; i < art_pkg::NUM_PWM; i++) begin
        level_r[i] <= (counter_r <= compare_r[i]);
      end
    end
  end

  // Polarity is applied after the flop so a change shows at once.
  assign PWM_OUT = level_r ^ polarity;
  assign PWM_OUT_EN_N =
    ~pwm_output_control_r[art_pkg::PWM_OE_LSB +: 4];

  // ****************************************************************
  // Capture channels
  // ****************************************************************
  assign cap_read[0] = RD && (ADDR == art_pkg::ADDR_CAPTURE_CH1);
  assign cap_read[1] = RD && (ADDR == art_pkg::ADDR_CAPTURE_CH2);

  for (genvar c = 0; c < art_pkg::NUM_CAP; c++) begin : g_cap
    art_capture_chan u_cap (
      .CLK        (CLK),
      .NRST       (NRST),
      .pin        (CAP_IN[c]),
      .rising_sel (cap_ctrl_r[2 + c]),
      .irq_en     (cap_ctrl_r[c]),
      .data_read  (cap_read[c]),
      .count      (counter_r),
      .flag_r     (cap_flag[c]),
      .value_r    (cap_value[c]),
      .irq        (CAP_IRQ[c])
    );
  end

  assign OVF_IRQ = timer_control_status_r[art_pkg::CSR_OVF] &&
                   timer_control_status_r[art_pkg::CSR_OVF_IE];

  // ****************************************************************
  // Read side
  // ****************************************************************
  always_comb begin
    rdata_nxt = art_pkg::RD_UNMAPPED;
    unique case (ADDR)
      art_pkg::ADDR_DUTY_CH3:    rdata_nxt = duty_r[3];
      art_pkg::ADDR_DUTY_CH2:    rdata_nxt = duty_r[2];
      art_pkg::ADDR_DUTY_CH1:    rdata_nxt = duty_r[1];
      art_pkg::ADDR_DUTY_CH0:    rdata_nxt = duty_r[0];
      art_pkg::ADDR_PWM_CTRL:    rdata_nxt = pwm_output_control_r;
      art_pkg::ADDR_TIMER_CSR:   rdata_nxt = timer_control_status_r;
      art_pkg::ADDR_COUNTER:     rdata_nxt = counter_r;
      art_pkg::ADDR_RELOAD:      rdata_nxt = reload_value_r;
      art_pkg::ADDR_CAPTURE_CSR: rdata_nxt = {2'b00, cap_ctrl_r,
                                              cap_flag};
      art_pkg::ADDR_CAPTURE_CH1: rdata_nxt = cap_value[0];
      art_pkg::ADDR_CAPTURE_CH2: rdata_nxt = cap_value[1];
      default: ;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rdata_r <= art_pkg::REG_RESET;
    end else if (RD) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= art_pkg::REG_RESET;
    end
  end

  assign RDATA = rdata_r;

endmodule // art_pwm_timer

// file: art_pkg.sv
package art_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_PWM = 4;
  localparam int NUM_CAP = 2;

  localparam logic [7:0] ADDR_DUTY_CH3      = 8'h73;
  localparam logic [7:0] ADDR_DUTY_CH2      = 8'h74;
  localparam logic [7:0] ADDR_DUTY_CH1      = 8'h75;
  localparam logic [7:0] ADDR_DUTY_CH0      = 8'h76;
  localparam logic [7:0] ADDR_PWM_CTRL      = 8'h77;
  localparam logic [7:0] ADDR_TIMER_CSR     = 8'h78;
  localparam logic [7:0] ADDR_COUNTER       = 8'h79;
  localparam logic [7:0] ADDR_RELOAD        = 8'h7a;
  localparam logic [7:0] ADDR_CAPTURE_CSR   = 8'h7b;
  localparam logic [7:0] ADDR_CAPTURE_CH1   = 8'h7c;
  localparam logic [7:0] ADDR_CAPTURE_CH2   = 8'h7d;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PWM_OE_LSB     = 4;
  localparam int PWM_POL_LSB    = 0;
  localparam int CSR_EXT_CLK    = 7;
  localparam int CSR_PRESC_LSB  = 4;
  localparam int CSR_RUN        = 3;
  localparam int CSR_FORCE      = 2;
  localparam int CSR_OVF_IE     = 1;
  localparam int CSR_OVF        = 0;
  localparam int CAP_EDGE_LSB   = 4;
  localparam int CAP_IE_LSB     = 2;
  localparam int CAP_FLAG_LSB   = 0;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] COUNT_TOP     = 8'hff;
  localparam int         PRESC_W       = 7;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

endpackage

// file: art_prescaler.sv
`timescale 1ns/100ps
module art_prescaler #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             NRST,
  // Control
  input  wire logic             run,
  input  wire logic             clear,
  input  wire logic             tick_in,
  input  wire logic [2:0]       ratio,
  // Output
  output logic                  tick_out
);

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] mask;

  // Ratio n divides by 2**n; a tick fires when the low n bits wrap.
  assign mask = WIDTH'((1 << ratio) - 1);
  assign tick_out = run && tick_in && ((cnt_r & mask) == mask);

  always_ff @(posedge CLK) begin
    if (!NRST || clear) begin
      cnt_r <= '0;
    end else if (run && tick_in) begin
      cnt_r <= cnt_r + WIDTH'(1);
    end
  end

endmodule // art_prescaler

// file: art_capture_chan.sv
`timescale 1ns/100ps
module art_capture_chan (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       NRST,
  // Control
  input  wire logic       pin,
  input  wire logic       rising_sel,
  input  wire logic       irq_en,
  input  wire logic       data_read,
  input  wire logic [7:0] count,
  // Status
  output logic            flag_r,
  output logic [7:0]      value_r,
  output logic            irq
);

  logic pin_r;
  logic edge_hit;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin;
    end
  end

  assign edge_hit = rising_sel ? (pin && !pin_r)
                               : (!pin && pin_r);

  // An edge in the read cycle is taken: the set wins over the clear.
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      flag_r  <= 1'b0;
      value_r <= art_pkg::REG_RESET;
    end else if (edge_hit && (!flag_r || data_read)) begin
      flag_r  <= 1'b1;
      value_r <= count;
    end else if (data_read) begin
      flag_r  <= 1'b0;
    end
  end

  assign irq = flag_r && irq_en;

endmodule // art_capture_chan

// file: art_pwm_timer_properties.sv
`timescale 1ns/100ps
module art_pwm_timer_properties (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       NRST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // Pins and requests
  input wire logic       EXT_TICK,
  input wire logic [3:0] PWM_OUT,
  input wire logic [3:0] PWM_OUT_EN_N,
  input wire logic [1:0] CAP_IN,
  input wire logic       OVF_IRQ,
  input wire logic [1:0] CAP_IRQ
);
  // ****************************************************************
  // Shadow of software writes
  // ****************************************************************
  // A polarity flip is judged only when the counter could not have
  // moved on the edge before, since the level follows it by a cycle.
  logic [3:0] pol_r;
  logic       run_r;
  logic       cwr_r;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pol_r <= 4'h0;
      run_r <= 1'b0;
      cwr_r <= 1'b1;
    end else begin
      if (WR && ADDR == 8'h77) pol_r <= WDATA[3:0];
      if (WR && ADDR == 8'h78) run_r <= WDATA[3];
      cwr_r <= WR && (ADDR == 8'h78 || ADDR == 8'h79);
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  oe_follow_a: assert property (WR && ADDR == 8'h77
    |=> PWM_OUT_EN_N == ~$past(WDATA[7:4])) else $error("enable wrong");
  pol_flip_a: assert property (WR && ADDR == 8'h77 && !run_r && !cwr_r
    |=> PWM_OUT == ($past(PWM_OUT) ^ $past(pol_r) ^ $past(WDATA[3:0])))
    else $error("polarity flip wrong");
  resv_zero_a: assert property (RD && ADDR == 8'h7b
    |=> RDATA[7:6] == 2'b00) else $error("reserved bits set");
  unmapped_a: assert property (RD && (ADDR < 8'h73 || ADDR > 8'h7d)
    |=> RDATA == 8'h00) else $error("unmapped read not zero");
  reset_clear_a: assert property ($rose(NRST) |-> PWM_OUT_EN_N == 4'hf
    && RDATA == 8'h00 && !OVF_IRQ && CAP_IRQ == 2'b00)
    else $error("not cleared by reset");
  cap_hold_a: assert property (CAP_IRQ[0] && !(RD && ADDR == 8'h7c)
    && !(WR && ADDR == 8'h7b) |=> CAP_IRQ[0]) else $error("capture irq lost");
  ovf_hold_a: assert property (OVF_IRQ && !(RD && ADDR == 8'h78)
    && !(WR && ADDR == 8'h78) |=> OVF_IRQ) else $error("overflow irq lost");
  ctl_read_a: assert property (RD && ADDR == 8'h77
    |=> RDATA == {~$past(PWM_OUT_EN_N), $past(pol_r)})
    else $error("control readback wrong");
  cover property (OVF_IRQ);
  cover property ($rose(CAP_IRQ[0]));
  cover property (WR && ADDR == 8'h77 && !run_r && !cwr_r);
endmodule // art_pwm_timer_properties

bind art_pwm_timer art_pwm_timer_properties art_pwm_timer_properties_inst (
  .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .EXT_TICK(EXT_TICK), .PWM_OUT(PWM_OUT),
  .PWM_OUT_EN_N(PWM_OUT_EN_N), .CAP_IN(CAP_IN), .OVF_IRQ(OVF_IRQ),
  .CAP_IRQ(CAP_IRQ));

// file: art_pin_model.sv
`timescale 1ns/100ps
module art_pin_model (
  // Clock
  input  wire logic       CLK,
  // Pins of the timer
  input  wire logic [3:0] PWM_OUT,
  input  wire logic [3:0] PWM_OUT_EN_N,
  output logic      [1:0] CAP_IN,
  output logic            EXT_TICK,
  // Board level of the output pads
  output logic      [3:0] pad
);
  initial begin
    CAP_IN = 2'b00;
    EXT_TICK = 1'b0;
  end
  // A released pad falls to its pull-down level.
  assign pad = PWM_OUT & ~PWM_OUT_EN_N;
  task set_cap(input int ch, input logic lvl);
    @(posedge CLK);
    CAP_IN[ch] <= lvl;
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(posedge CLK);
      EXT_TICK <= 1'b1;
      @(posedge CLK);
      EXT_TICK <= 1'b0;
    end
  endtask
endmodule // art_pin_model

// file: pwm_autoreload_timer_capture_bench.sv
`timescale 1ns/100ps
module pwm_autoreload_timer_capture_bench;
  logic       CLK = 1'b0;
  logic       NRST = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic [7:0] RDATA;
  logic [3:0] PWM_OUT, PWM_OUT_EN_N, pad, exp;
  logic [1:0] CAP_IN, CAP_IRQ;
  logic       EXT_TICK, OVF_IRQ;
  logic [7:0] duty [4] = '{8'h00, 8'h80, 8'hff, 8'h40};
  logic [7:0] vals [5] = '{8'h00, 8'h40, 8'h41, 8'h80, 8'hff};
  int         n_mismatch = 0;
  int         check_count = 0;
  int         i, c;
  always #2.5 CLK = ~CLK;
  art_pwm_timer art_pwm_timer_inst (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EXT_TICK(EXT_TICK),
    .PWM_OUT(PWM_OUT), .PWM_OUT_EN_N(PWM_OUT_EN_N), .CAP_IN(CAP_IN),
    .OVF_IRQ(OVF_IRQ), .CAP_IRQ(CAP_IRQ));
  art_pin_model art_pin_model_inst (.CLK(CLK), .PWM_OUT(PWM_OUT),
    .PWM_OUT_EN_N(PWM_OUT_EN_N), .CAP_IN(CAP_IN), .EXT_TICK(EXT_TICK),
    .pad(pad));
  // ****************************************************************
  // Access and checking tasks
  // ****************************************************************
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] seen, input logic [7:0] e);
    check_count++;
    if (seen !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, e, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
  endtask
  task rchk(input string what, input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(what, RDATA, e);
  endtask
  // Waits for an interrupt line; 2 selects the overflow request.
  task wait_irq(input int w);
    for (c = 0; c < 600; c++) begin
      #1;
      if ((w == 2 ? OVF_IRQ : CAP_IRQ[w]) === 1'b1) return;
      @(posedge CLK);
    end
    chk("irq wait", 8'h00, 8'h01);
    end_of_test;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    for (i = 8'h72; i <= 8'h7e; i++) rchk("reset reg", i[7:0], 8'h00);
    chk("reset enables", {4'h0, PWM_OUT_EN_N}, 8'h0f);
    $display("reset test done");
    for (i = 0; i < 4; i++) wr(8'h76 - i[7:0], duty[i]);
    for (i = 0; i < 4; i++) rchk("duty", 8'h76 - i[7:0], duty[i]);
    wr(8'h77, 8'ha0);
    rchk("pwm control", 8'h77, 8'ha0);
    chk("enables", {4'h0, PWM_OUT_EN_N}, 8'h05);
    wr(8'h7a, 8'hf0);
    wr(8'h79, 8'hfe);
    rchk("reload", 8'h7a, 8'hf0);
    wr(8'h7b, 8'hff);
    rchk("capture csr", 8'h7b, 8'h3c);
    wr(8'h7c, 8'h55);
    wr(8'h7d, 8'haa);
    rchk("capture 1 ro", 8'h7c, 8'h00);
    rchk("capture 2 ro", 8'h7d, 8'h00);
    $display("register test done");
    wr(8'h78, 8'h7a);
    wait_irq(2);
    rchk("count after wrap", 8'h79, 8'hf0);
    wr(8'h78, 8'h02);
    rchk("status flag", 8'h78, 8'h03);
    chk("ovf irq", {7'h0, OVF_IRQ}, 8'h00);
    rchk("status clear", 8'h78, 8'h02);
    $display("overflow test done");
    wr(8'h77, 8'hf0);
    for (i = 0; i < 5; i++) begin
      wr(8'h79, vals[i]);
      repeat (3) @(posedge CLK);
      for (c = 0; c < 4; c++) exp[c] = vals[i] <= duty[c];
      #1 chk("pwm level", {4'h0, PWM_OUT}, {4'h0, exp});
      wr(8'h77, 8'hff);
      chk("pwm inverted", {4'h0, PWM_OUT}, {4'h0, ~exp});
      wr(8'h77, 8'h50);
      chk("pads", {4'h0, pad}, {4'h0, exp & 4'h5});
      wr(8'h77, 8'hf0);
    end
    $display("pwm test done");
    wr(8'h79, 8'h5a);
    wr(8'h7b, 8'h1c);
    art_pin_model_inst.set_cap(0, 1'b1);
    wait_irq(0);
    rchk("capture flag", 8'h7b, 8'h1d);
    wr(8'h79, 8'h66);
    art_pin_model_inst.set_cap(0, 1'b0);
    art_pin_model_inst.set_cap(0, 1'b1);
    repeat (3) @(posedge CLK);
    rchk("held capture", 8'h7c, 8'h5a);
    chk("irq after read", {6'h0, CAP_IRQ}, 8'h00);
    rchk("flag cleared", 8'h7b, 8'h1c);
    art_pin_model_inst.set_cap(1, 1'b1);
    repeat (3) @(posedge CLK);
    chk("wrong edge", {6'h0, CAP_IRQ}, 8'h00);
    art_pin_model_inst.set_cap(1, 1'b0);
    wait_irq(1);
    rchk("capture 2", 8'h7d, 8'h66);
    wr(8'h7b, 8'h14);
    art_pin_model_inst.set_cap(1, 1'b1);
    art_pin_model_inst.set_cap(1, 1'b0);
    repeat (3) @(posedge CLK);
    chk("masked irq", {6'h0, CAP_IRQ}, 8'h00);
    rchk("masked flag", 8'h7b, 8'h16);
    $display("capture test done");
    wr(8'h79, 8'h10);
    wr(8'h78, 8'h88);
    art_pin_model_inst.ticks(5);
    wr(8'h78, 8'h00);
    rchk("external count", 8'h79, 8'h15);
    wr(8'h78, 8'h04);
    rchk("forced reload", 8'h79, 8'hf0);
    rchk("force bit", 8'h78, 8'h00);
    $display("external clock test done");
    end_of_test;
  end
endmodule // pwm_autoreload_timer_capture_bench
